/* hw/irq_ack_pkg.sv */
package irq_ack_pkg;

	// source map
	localparam int              NUM_SRC           = 64;
	localparam int              FIXED_SRC_LAST    = 7;
	localparam int              CHAN_FIRST_SRC    = 27;
	localparam int              NUM_CHAN          = 32;
	localparam int              GLOBAL_FLAG_SRC   = 59;

	// avalon byte offsets
	localparam logic [7:0]      OFS_GLOBAL_SW_ACK = 8'h00;
	localparam logic [7:0]      OFS_CTL0_SW_ACK   = 8'h20;
	localparam logic [7:0]      OFS_CTL1_SW_ACK   = 8'h24;
	localparam logic [7:0]      OFS_ACK_LP0       = 8'h40;
	localparam logic [7:0]      OFS_ACK_LP1       = 8'h44;
	localparam logic [7:0]      OFS_LOW_POWER     = 8'h48;
	localparam logic [7:0]      OFS_CHAN_FLAGS    = 8'h50;
	localparam logic [7:0]      OFS_CHAN_CLEAR    = 8'h54;
	localparam logic [7:0]      OFS_GLOBAL_FLAG   = 8'h58;

	// field positions
	localparam int              LP_LEVEL_LSB      = 4;
	localparam int              LPC_ENABLE_BIT    = 7;
	localparam int              LPC_MASK_LSB      = 4;
	localparam int              GEC_BIT           = 0;

	// reset values
	localparam logic [7:0]      ACK_LP_RST        = 8'h00;
	localparam logic [7:0]      LOW_POWER_RST     = 8'h00;
	localparam logic [31:0]     CHAN_FLAGS_RST    = 32'h0000_0000;

	// ranking: priority code doubled, fixed sources between codes 3 and 4
	localparam logic [3:0]      FIXED_RANK        = 4'h7;
	localparam logic [2:0]      MAX_WAKE_MASK     = 3'h6;

	typedef struct packed {
		logic       found;
		logic [5:0] src;
		logic [2:0] level;
		logic [3:0] rank;
	} win_s;

	typedef enum logic [2:0] {
		TGT_CTL0   = 3'b001,
		TGT_CTL1   = 3'b010,
		TGT_GLOBAL = 3'b100
	} target_e;

endpackage : irq_ack_pkg

/* hw/irq_ack_wakeup.sv */
// How it works
// - explicit and implicit acknowledges behave alike
// - level acknowledge picks highest priority in level
// - level acknowledge stores level and priority
// - software acknowledge picks highest level then priority
// - software acknowledge stores level and priority
// - no source: zero vector; software acknowledge clears level/priority
// - global software acknowledge spans both controllers
// - global level acknowledge spans both controllers
// - ten byte-wide acknowledge registers return vectors
// - equal keys: first controller wins
// - higher second controller request wins
// - wake mask clamped to 0 through 6
// - wake path is purely combinational
// - wake when level exceeds effective mask
// - both wake outputs combined and forwarded
// - sources 27-58 are channel flags, write-one clear
// - source 59 global flag, above unused
// - priority code 000 lowest, 111 highest
// - fixed sources rank midpoint, priority reads zero
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module irq_ack_wakeup #(
	parameter logic [7:0] VEC_BASE0 = 8'h40,
	parameter logic [7:0] VEC_BASE1 = 8'h80
) (
	// clock, reset, enable
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic                   ce,
	// avalon-mm slave
	input  wire logic [7:0]             address,
	input  wire logic                   read,
	input  wire logic                   write,
	input  wire logic [31:0]            writedata,
	input  wire logic [3:0]             byteenable,
	output logic      [31:0]            readdata,
	output logic                        waitrequest,
	// implicit acknowledge from the core
	input  wire logic                   ack_req,
	input  wire logic [2:0]             ack_level,
	output logic                        ack_done,
	output logic      [7:0]             ack_vector,
	// unmasked active requests and their level/priority fields
	input  wire logic [63:0]            src_req0,
	input  wire logic [63:0][5:0]       src_level_priority0,
	input  wire logic [63:0]            src_req1,
	input  wire logic [63:0][5:0]       src_level_priority1,
	// coprocessor flag events
	input  wire logic [31:0]            chan_event,
	input  wire logic                   global_event,
	// stop mode and wake-up
	input  wire logic                   core_stopped,
	output logic                        wake0,
	output logic                        wake1,
	output logic                        wake_any
);

	function automatic irq_ack_pkg::win_s pick(
		input logic [63:0]      req,
		input logic [63:0][5:0] cfg,
		input logic             use_lvl,
		input logic [2:0]       lvl,
		input logic             fixed
	);
		irq_ack_pkg::win_s w;
		logic [2:0]        l;
		logic [3:0]        r;
		w = '0;
		for (int i = 0; i < irq_ack_pkg::NUM_SRC; i++) begin
			l = cfg[i][5:3];
			r = {cfg[i][2:0], 1'b0};
			if (fixed && i >= 1 && i <= irq_ack_pkg::FIXED_SRC_LAST) begin
				l = 3'(i);
				r = irq_ack_pkg::FIXED_RANK;
			end
			// level first, then priority
			if (req[i] && l != 3'h0 && (!use_lvl || l == lvl) &&
				(!w.found || {l, r} > {w.level, w.rank})) begin
				w.found = 1'b1;
				w.src   = 6'(i);
				w.level = l;
				w.rank  = r;
			end
		end
		return w;
	endfunction : pick

	function automatic logic wake_hit(
		input logic [63:0]      req,
		input logic [63:0][5:0] cfg,
		input logic             fixed,
		input logic [2:0]       mask
	);
		logic       hit;
		logic [2:0] l;
		hit = 1'b0;
		for (int i = 0; i < irq_ack_pkg::NUM_SRC; i++) begin
			l = cfg[i][5:3];
			if (fixed && i >= 1 && i <= irq_ack_pkg::FIXED_SRC_LAST) begin
				l = 3'(i);
			end
			if (req[i] && l > mask) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : wake_hit

	// state
	logic                  phase;
	logic [7:0]            ack_lp0;
	logic [7:0]            ack_lp1;
	logic [7:0]            low_power_irq_control;
	logic [31:0]           coproc_channel_flag;
	logic                  coproc_global_flag;

	// second controller map: 27..58 channel flags, 59 global, above unused
	logic [63:0]           req1_eff;
	assign req1_eff = {4'h0, coproc_global_flag, coproc_channel_flag,
		src_req1[26:0]};

	// bus decode
	logic                  bus_req;
	logic                  bus_go;
	logic                  bus_done;
	logic                  is_level_blk;
	logic                  bus_ack_read;
	assign bus_req      = read | write;
	assign bus_go       = bus_req & ~phase & ~ack_req;
	assign bus_done     = bus_req & phase & ce;
	assign waitrequest  = bus_req & ~(phase & ce);
	assign is_level_blk = address[7:5] == 3'b000;
	assign bus_ack_read = read & (is_level_blk | address == irq_ack_pkg::OFS_CTL0_SW_ACK |
		address == irq_ack_pkg::OFS_CTL1_SW_ACK);

	// acknowledge engine shared by bus reads and core cycles
	irq_ack_pkg::target_e  tgt;
	logic [2:0]            sel_lvl;
	logic                  use_lvl;
	logic                  eng_go;
	assign tgt = ack_req ? irq_ack_pkg::TGT_GLOBAL :
		address == irq_ack_pkg::OFS_CTL0_SW_ACK ? irq_ack_pkg::TGT_CTL0 :
		address == irq_ack_pkg::OFS_CTL1_SW_ACK ? irq_ack_pkg::TGT_CTL1 :
		irq_ack_pkg::TGT_GLOBAL;
	assign sel_lvl = ack_req ? ack_level : is_level_blk ? address[4:2] : 3'h0;
	assign use_lvl = sel_lvl != 3'h0;
	assign eng_go  = ack_req | (bus_go & bus_ack_read);

	irq_ack_pkg::win_s     w0;
	irq_ack_pkg::win_s     w1;
	irq_ack_pkg::win_s     win;
	logic                  ctl1_better;
	logic                  win_ctl1;
	logic [7:0]            win_vec;
	logic [7:0]            win_lp;
	logic                  win_fixed;
	assign w0 = pick(src_req0, src_level_priority0, use_lvl, sel_lvl, 1'b1);
	assign w1 = pick(req1_eff, src_level_priority1, use_lvl, sel_lvl, 1'b0);
	// second controller only on a strictly greater key
	assign ctl1_better = w1.found & (~w0.found | ({w1.level, w1.rank} > {w0.level, w0.rank}));
	assign win_ctl1    = (tgt == irq_ack_pkg::TGT_CTL1) |
		((tgt == irq_ack_pkg::TGT_GLOBAL) & ctl1_better);
	assign win         = win_ctl1 ? w1 : w0;
	assign win_vec     = !win.found ? 8'h00 :
		(win_ctl1 ? VEC_BASE1 : VEC_BASE0) + {2'b00, win.src};
	assign win_fixed   = ~win_ctl1 & (win.src != 6'h00) &
		(win.src <= 6'(irq_ack_pkg::FIXED_SRC_LAST));
	assign win_lp      = {1'b0, win.level, 1'b0,
		win_fixed ? 3'h0 : win.rank[3:1]};

	// plain register reads
	logic [31:0]           reg_word;
	assign reg_word =
		address == irq_ack_pkg::OFS_ACK_LP0     ? {24'h00_0000, ack_lp0} :
		address == irq_ack_pkg::OFS_ACK_LP1     ? {24'h00_0000, ack_lp1} :
		address == irq_ack_pkg::OFS_LOW_POWER   ? {24'h00_0000, low_power_irq_control} :
		address == irq_ack_pkg::OFS_CHAN_FLAGS  ? coproc_channel_flag :
		address == irq_ack_pkg::OFS_GLOBAL_FLAG ? {31'h0000_0000, coproc_global_flag} :
		32'h0000_0000;

	// write strobes take effect on the completing edge
	logic [31:0]           be_mask;
	logic [31:0]           chan_clear;
	logic                  global_clear;
	logic                  lpc_write;
	assign be_mask      = {{8{byteenable[3]}}, {8{byteenable[2]}},
		{8{byteenable[1]}}, {8{byteenable[0]}}};
	assign chan_clear   = (bus_done & write & address == irq_ack_pkg::OFS_CHAN_CLEAR) ?
		(writedata & be_mask) : 32'h0000_0000;
	assign global_clear = bus_done & write & byteenable[0] &
		(address == irq_ack_pkg::OFS_GLOBAL_FLAG) & writedata[irq_ack_pkg::GEC_BIT];
	assign lpc_write    = bus_done & write & byteenable[0] &
		(address == irq_ack_pkg::OFS_LOW_POWER);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			phase    <= 1'b0;
			readdata <= 32'h0000_0000;
		end else if (ce) begin
			phase <= bus_go;
			if (bus_go && read) begin
				readdata <= bus_ack_read ? {24'h00_0000, win_vec} : reg_word;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ack_done   <= 1'b0;
			ack_vector <= 8'h00;
		end else if (ce) begin
			ack_done <= ack_req;
			if (ack_req) begin
				ack_vector <= win_vec;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ack_lp0 <= irq_ack_pkg::ACK_LP_RST;
			ack_lp1 <= irq_ack_pkg::ACK_LP_RST;
		end else if (ce && eng_go) begin
			if (win.found) begin
				if (win_ctl1) begin
					ack_lp1 <= win_lp;
				end else begin
					ack_lp0 <= win_lp;
				end
			end else if (!use_lvl) begin
				if (tgt != irq_ack_pkg::TGT_CTL1) begin
					ack_lp0 <= irq_ack_pkg::ACK_LP_RST;
				end
				if (tgt != irq_ack_pkg::TGT_CTL0) begin
					ack_lp1 <= irq_ack_pkg::ACK_LP_RST;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			low_power_irq_control <= irq_ack_pkg::LOW_POWER_RST;
			coproc_channel_flag   <= irq_ack_pkg::CHAN_FLAGS_RST;
			coproc_global_flag    <= 1'b0;
		end else if (ce) begin
			if (lpc_write) begin
				low_power_irq_control <= writedata[7:0];
			end
			// a set in the clearing cycle wins
			coproc_channel_flag <= (coproc_channel_flag & ~chan_clear) | chan_event;
			coproc_global_flag  <= (coproc_global_flag & ~global_clear) | global_event;
		end
	end

	// wake-up: no clocked element between requests and outputs
	logic                  stop_wake_enable;
	logic [2:0]            stop_wake_mask_level;
	logic [2:0]            eff_mask;
	logic                  wake_arm;
	assign stop_wake_enable     = low_power_irq_control[irq_ack_pkg::LPC_ENABLE_BIT];
	assign stop_wake_mask_level = low_power_irq_control[irq_ack_pkg::LPC_MASK_LSB +: 3];
	assign eff_mask = (stop_wake_mask_level > irq_ack_pkg::MAX_WAKE_MASK) ?
		irq_ack_pkg::MAX_WAKE_MASK : stop_wake_mask_level;
	assign wake_arm = core_stopped & stop_wake_enable;
	assign wake0    = wake_arm & wake_hit(src_req0, src_level_priority0, 1'b1, eff_mask);
	assign wake1    = wake_arm & wake_hit(req1_eff, src_level_priority1, 1'b0, eff_mask);
	assign wake_any = wake0 | wake1;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	bus_answer_a: assert property (bus_go && read && ce |=> !waitrequest || !ce)
		else $error("bus read not answered after one wait cycle");
	bus_vector_a: assert property (bus_go && bus_ack_read && ce
		|=> readdata == {24'h00_0000, $past(win_vec)})
		else $error("bus acknowledge read returned wrong vector");
	port_vector_a: assert property (ack_req && ce |=> ack_done && ack_vector == $past(win_vec))
		else $error("core acknowledge vector mismatch");
	level_filter_a: assert property (win.found && use_lvl |-> win.level == sel_lvl)
		else $error("level acknowledge winner from wrong level");
	lp_store_a: assert property (eng_go && ce && win.found
		|=> ($past(win_ctl1) ? ack_lp1 : ack_lp0) == $past(win_lp))
		else $error("level/priority not stored");
	sw_none_a: assert property (ack_req && ce && ack_level == 3'h0 && !win.found
		|=> ack_vector == 8'h00 && ack_lp0 == 8'h00 && ack_lp1 == 8'h00)
		else $error("empty software acknowledge not zero");
	tie_first_a: assert property (tgt == irq_ack_pkg::TGT_GLOBAL && w0.found && w1.found &&
		{w0.level, w0.rank} == {w1.level, w1.rank} |-> !win_ctl1)
		else $error("tie not given to first controller");
	second_wins_a: assert property (tgt == irq_ack_pkg::TGT_GLOBAL && w1.found &&
		{w1.level, w1.rank} > {w0.level, w0.rank} |-> win_ctl1)
		else $error("higher second controller request lost");
	wake_mask_a: assert property (eff_mask == ((stop_wake_mask_level == 3'h7) ?
		irq_ack_pkg::MAX_WAKE_MASK : stop_wake_mask_level))
		else $error("wake mask not clamped");
	wake_arm_a: assert property (!wake_arm |-> !wake_any)
		else $error("wake while disarmed");
	wake_awake_a: assert property (!core_stopped |-> !wake0 && !wake1)
		else $error("wake raised while core running");
	// fixed source 7 is level 7, above any clamped mask
	wake_top_a: assert property (wake_arm && src_req0[7] |-> wake0 && wake_any)
		else $error("level 7 request did not wake");
	chan_set_a: assert property (ce && chan_event != 32'h0000_0000
		|=> (coproc_channel_flag & $past(chan_event)) == $past(chan_event))
		else $error("channel event lost against clear");

	// clears that are not overridden by a set in the same cycle
	logic [31:0]           chan_drop;
	logic                  global_drop;
	assign chan_drop   = chan_clear & ~chan_event;
	assign global_drop = global_clear & ~global_event;

	chan_clear_a: assert property (ce && chan_drop != 32'h0000_0000
		|=> (coproc_channel_flag & $past(chan_drop)) == 32'h0000_0000)
		else $error("channel flag not cleared");
	global_set_a: assert property (ce && global_event |=> coproc_global_flag)
		else $error("global flag event lost");
	global_clear_a: assert property (ce && global_drop |=> !coproc_global_flag)
		else $error("global flag not cleared");
	fixed_prio_a: assert property (win_fixed |-> win_lp[2:0] == 3'h0)
		else $error("fixed source reports nonzero priority");
	// an empty level acknowledge leaves both stores alone
	level_empty_a: assert property (eng_go && ce && use_lvl && !win.found
		|=> $stable(ack_lp0) && $stable(ack_lp1))
		else $error("empty level acknowledge changed level/priority");
	// an empty controller acknowledge clears only its own store
	ctl_empty_a: assert property (eng_go && ce && !use_lvl && !win.found &&
		tgt == irq_ack_pkg::TGT_CTL0 |=> ack_lp0 == 8'h00 && $stable(ack_lp1))
		else $error("empty first controller acknowledge wrong");
	// the store is read only from the bus
	lp_readonly_a: assert property (bus_done && write && !ack_req &&
		address == irq_ack_pkg::OFS_ACK_LP0 |=> $stable(ack_lp0))
		else $error("level/priority store written by bus");
	// read data stands between reads
	read_hold_a: assert property (!(bus_go && read && ce) |=> $stable(readdata))
		else $error("read data changed without a read");
	stall_hold_a: assert property (!ce && bus_req |-> waitrequest)
		else $error("bus answered while frozen");

	port_level_c: cover property (ack_req && ce && ack_level != 3'h0 && win.found);
	sw_empty_c:   cover property (bus_go && bus_ack_read && !use_lvl && !win.found);
	second_c:     cover property (eng_go && win_ctl1 && tgt == irq_ack_pkg::TGT_GLOBAL);
	wake_c:       cover property (wake_any);
	wake_top_c:   cover property (wake_arm && stop_wake_mask_level == 3'h7 && wake_any);

endmodule : irq_ack_wakeup

/* bench/core_model.sv */
`timescale 1ns/1ps
module core_model (
	// clock
	input  wire logic       clk,
	// commands from the bench
	input  wire logic       go,
	input  wire logic [2:0] lvl,
	input  wire logic       stop,
	// acknowledge cycle and stop state
	output logic            ack_req,
	output logic [2:0]      ack_level,
	output logic            core_stopped
);
	// level lines carry junk outside an acknowledge cycle
	always_ff @(posedge clk) begin
		ack_req      <= go;
		ack_level    <= go ? lvl : ~ack_level;
		core_stopped <= stop;
	end
endmodule : core_model

/* bench/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
	logic             clk, rst_b, read, write, waitrequest, go, stop, gev;
	logic             ack_req, ack_done, core_stopped, wake0, wake1, wake_any;
	logic [2:0]       lvl, ack_level;
	logic [3:0]       be;
	logic [7:0]       address, ack_vector;
	logic [31:0]      writedata, readdata, ev, q;
	logic [63:0]      sreq0, sreq1;
	logic [63:0][5:0] lp0, lp1;
	int               err_total, n_compared, seed, chan_m, gflag, vec, al, wm, clr, i;
	int               lpr[2];

	irq_ack_wakeup i_irq_ack_wakeup (.clk(clk), .rst_b(rst_b), .ce(1'b1), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(be),
		.readdata(readdata), .waitrequest(waitrequest), .ack_req(ack_req),
		.ack_level(ack_level), .ack_done(ack_done), .ack_vector(ack_vector),
		.src_req0(sreq0), .src_level_priority0(lp0), .src_req1(sreq1),
		.src_level_priority1(lp1), .chan_event(ev), .global_event(gev),
		.core_stopped(core_stopped), .wake0(wake0), .wake1(wake1), .wake_any(wake_any));
	core_model i_core_model (.clk(clk), .go(go), .lvl(lvl), .stop(stop), .ack_req(ack_req),
		.ack_level(ack_level), .core_stopped(core_stopped));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// best request of one controller: {key, priority, source} or -1
	function automatic int best(input int c, input int l);
		int b, k, lv, pr, rk, act;
		b = -1;
		for (int s = 1; s < 64; s++) begin
			lv = c ? lp1[s][5:3] : (s < 8 ? s : lp0[s][5:3]);
			pr = c ? lp1[s][2:0] : (s < 8 ? 0 : lp0[s][2:0]);
			rk = (c == 0 && s < 8) ? 7 : pr * 2;
			act = c ? (s < 27 ? sreq1[s] : s < 59 ? chan_m[s-27] : s == 59 ? gflag : 0)
				: sreq0[s];
			k = lv * 16 + rk;
			if (act && lv != 0 && (l == 0 || l == lv) && (b < 0 || k > b >> 9))
				b = (k << 9) | (pr << 6) | s;
		end
		return b;
	endfunction : best

	// g: 0 first controller, 1 second, 2 global; l: 0 software, else level
	task automatic model_ack(input int g, input int l);
		int b0, b1, w, b;
		b0 = best(0, l);
		b1 = best(1, l);
		w = g == 2 ? (b1 >= 0 && (b0 < 0 || b1 >> 9 > b0 >> 9)) : g;
		b = w ? b1 : b0;
		vec = b < 0 ? 0 : (w ? 8'h80 : 8'h40) + (b & 63);
		if (b >= 0)
			lpr[w] = ((b >> 13) << 4) | ((b >> 6) & 7);
		else if (l == 0) begin
			lpr[w] = 0;
			if (g == 2)
				lpr[1 - w] = 0;
		end
	endtask : model_ack

	function automatic int wake_m(input int c, input int m);
		int r;
		r = 0;
		for (int l = 1; l < 8; l++)
			if (l > ((m & 7) > 6 ? 6 : (m & 7)) && best(c, l) >= 0)
				r = 1;
		return (m >> 3) & r;
	endfunction : wake_m

	task automatic results();
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		for (int n = 0; n < 20; n++) begin
			@(posedge clk);
			if (waitrequest === 1'b0) begin
				q = readdata;
				read <= 1'b0;
				write <= 1'b0;
				return;
			end
		end
		err_total++;
		results();
	endtask : bus

	initial begin
		seed = 34580;
		{rst_b, read, write, go, stop, gev, lvl, address, writedata, ev} = '0;
		{sreq0, sreq1, lp0, lp1} = '0;
		be = 4'hF;
		{err_total, n_compared, chan_m, gflag, lpr[0], lpr[1]} = '0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
		for (int r = 0; r < 4; r++) begin
			bus(1'b0, r < 3 ? 8'(8'h40 + 4 * r) : 8'hFC, 32'h0000_0000);
			`CHK("reset or unmapped read", 0, q);
		end
		for (int it = 0; it < 14; it++) begin
			for (int s = 0; s < 64; s++) begin
				lp0[s] <= 6'($random(seed));
				lp1[s] <= 6'($random(seed));
			end
			if (it == 1) begin
				lp0[9] <= 6'h2D;
				lp1[5] <= 6'h2D;
			end
			sreq0 <= it == 1 ? 64'h0000_0000_0000_0200 : it < 13 ?
				{$random(seed), $random(seed)} & {$random(seed), $random(seed)} : 64'h0;
			sreq1 <= it == 1 ? 64'h0000_0000_0000_0020 : it < 13 ?
				{$random(seed), $random(seed)} & {$random(seed), $random(seed)} : 64'h0;
			ev <= it > 1 && it < 13 ? $random(seed) & $random(seed) : 32'h0;
			gev <= it > 1 && it < 13 ? 1'($random(seed)) : 1'b0;
			@(posedge clk);
			chan_m = chan_m | ev;
			gflag = gflag | gev;
			ev <= 32'h0;
			gev <= 1'b0;
			clr = it == 13 ? -1 : $random(seed);
			bus(1'b1, 8'h54, clr);
			chan_m = chan_m & ~clr;
			bus(1'b1, 8'h58, clr);
			gflag = gflag & ~clr & 1;
			bus(1'b0, 8'h50, 32'h0);
			`CHK("channel flags", chan_m, q);
			bus(1'b0, 8'h58, 32'h0);
			`CHK("global flag", gflag, q[0]);
			for (int k = 0; k < 10; k++) begin
				bus(1'b0, 8'(4 * k), 32'h0);
				model_ack(k < 8 ? 2 : k - 8, k < 8 ? k : 0);
				`CHK("ack vector", vec, q[7:0]);
				bus(1'b0, 8'h40, 32'h0);
				`CHK("level prio 0", lpr[0], q[7:0]);
				bus(1'b0, 8'h44, 32'h0);
				`CHK("level prio 1", lpr[1], q[7:0]);
			end
			al = $random(seed) & 7;
			@(posedge clk);
			go <= 1'b1;
			lvl <= 3'(al);
			@(posedge clk);
			go <= 1'b0;
			for (i = 0; i < 10; i++) begin
				@(negedge clk);
				if (ack_done === 1'b1)
					break;
			end
			if (i == 10) begin
				err_total++;
				results();
			end
			model_ack(2, al);
			`CHK("core ack vector", vec, ack_vector);
			wm = $random(seed) & 15;
			be <= 4'h1;
			bus(1'b1, 8'h48, wm << 4);
			be <= 4'hF;
			bus(1'b0, 8'h48, 32'h0);
			`CHK("low power ctl", wm << 4, q[7:0]);
			stop <= 1'b1;
			repeat (2) @(posedge clk);
			@(negedge clk);
			`CHK("wake0", wake_m(0, wm), wake0);
			`CHK("wake1", wake_m(1, wm), wake1);
			`CHK("wake any", wake_m(0, wm) | wake_m(1, wm), wake_any);
			stop <= 1'b0;
		end
		results();
	end
endmodule : tb
